// ==== verilog/smss_regs.svh ====
// register offsets, field positions, reset values and timing counts
// assumes a 200 MHz clock and a byte-addressed wishbone slave
`ifndef SMSS_REGS_SVH
`define SMSS_REGS_SVH

`define SMSS_ADR_W              8
`define SMSS_OFS_CMD            8'h00
`define SMSS_OFS_MON            8'h04
`define SMSS_OFS_STAT           8'h08
`define SMSS_OFS_IRQ_STAT       8'h0C
`define SMSS_OFS_IRQ_MASK       8'h10
`define SMSS_OFS_REF_POS        8'h14
`define SMSS_OFS_ALARM          8'h18

// command / monitor layout
`define SMSS_B_REF_REQ          0
`define SMSS_B_ZP_REQ           1
`define SMSS_B_EMG              2
`define SMSS_B_ALM_RST          3
`define SMSS_B_MODE_LO          4
`define SMSS_B_MODE_HI          6
`define SMSS_B_CHAN_A           7
`define SMSS_B_CHAN_B           8
`define SMSS_CMD_W              7
`define SMSS_CMD_RST            7'h00

// status layout
`define SMSS_S_DONE             0
`define SMSS_S_ERR              1
`define SMSS_S_MODE_LO          2
`define SMSS_S_MODE_HI          4
`define SMSS_S_STO              5
`define SMSS_S_ALARM            6
`define SMSS_S_ZP               7

// interrupt layout
`define SMSS_IRQ_W              5
`define SMSS_I_DONE             0
`define SMSS_I_ERR              1
`define SMSS_I_ALARM            2
`define SMSS_I_STO              3
`define SMSS_I_MODE             4
`define SMSS_IRQ_MASK_RST       5'h00

// alarms
`define SMSS_ALARM_W            8
`define SMSS_ALARM_KEEP_MASK    8'hC0

// control cycle timing
`define SMSS_CLK_PERIOD_PS      5000
`define SMSS_CTRL_CYCLE_NS      1000
`define SMSS_CTRL_CYCLES        ((`SMSS_CTRL_CYCLE_NS * 1000) / `SMSS_CLK_PERIOD_PS)
`define SMSS_CNT_W              8

`endif

// ==== verilog/smss_pkg.sv ====
// types shared by the status logic and its alarm latch
// assumes the constants header is included where offsets are needed
`default_nettype none

package smss_pkg;

	typedef enum logic [1:0] {
		SMSS_MODE_POSITION,
		SMSS_MODE_SPEED,
		SMSS_MODE_TORQUE_LIMIT,
		SMSS_MODE_CONT_TORQUE
	} smss_mode_t;

	typedef logic [7:0] smss_alarm_vec_t;

endpackage

`default_nettype wire

// ==== verilog/smss_alarm_if.sv ====
// carrier between the status core and the alarm latch
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none

interface smss_alarm_if;
	import smss_pkg::*;
	smss_alarm_vec_t event_set;
	logic            reset_pulse;
	smss_alarm_vec_t active;
	logic            raised;

	modport core  (output event_set, output reset_pulse, input active, input raised);
	modport latch (input event_set, input reset_pulse, output active, output raised);
endinterface

`default_nettype wire

// ==== verilog/smss_alarm.sv ====
// sticky alarm latch with per-alarm reset protection
// assumes the reset pulse lasts one clock and events are synchronous
`timescale 1ns/1ps
`default_nettype none
`include "smss_regs.svh"

module smss_alarm
	import smss_pkg::*;
(
	input  wire logic     clk_i,
	input  wire logic     rst_i,
	smss_alarm_if.latch   alm
);

	smss_alarm_vec_t active_q;
	wire  [`SMSS_ALARM_W-1:0] active_d;
	logic            raised_q;

	// some alarms survive a reset request and need a power cycle
	localparam smss_alarm_vec_t KEEP = `SMSS_ALARM_KEEP_MASK;

	genvar gi;
	generate
		for (gi = 0; gi < `SMSS_ALARM_W; gi = gi + 1) begin : g_bit
			// a new event in the reset cycle keeps the alarm on
			assign active_d[gi] = alm.event_set[gi] ? 1'b1 :
				(alm.reset_pulse && !KEEP[gi]) ? 1'b0 : active_q[gi];
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q <= 8'h00;
			raised_q <= 1'b0;
		end else begin
			active_q <= active_d;
			raised_q <= |(alm.event_set & ~active_q);
		end
	end

	assign alm.active = active_q;
	assign alm.raised = raised_q;

endmodule

`default_nettype wire

// ==== verilog/smss_top.sv ====
// servo mode, command and status signal logic behind a wishbone slave
// assumes synchronous pins, one 200 MHz clock and a classic wishbone master
`timescale 1ns/1ps
`default_nettype none
`include "smss_regs.svh"

module smss_top
	import smss_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        ext_ref_point_set_request_i,
	input  wire logic        ext_zero_pulse_recreate_request_i,
	input  wire logic        ext_controller_emergency_stop_i,
	input  wire logic        ext_alarm_reset_input_i,
	input  wire logic [2:0]  ext_mode_select_i,
	input  wire logic        safety_channel_a_input_i,
	input  wire logic        safety_channel_b_input_i,
	input  wire logic        sto_shutoff_i,
	input  wire logic [31:0] position_i,
	input  wire logic        position_valid_i,
	input  wire logic [7:0]  alarm_event_i,
	output logic             ref_point_set_request_o,
	output logic             ref_point_set_complete_o,
	output logic             ref_point_set_error_o,
	output logic [31:0]      ref_point_data_o,
	output logic             zero_pulse_recreate_request_o,
	output logic             controller_emergency_stop_o,
	output logic             alarm_reset_input_o,
	output logic             current_mode_bit1_o,
	output logic             current_mode_bit2_o,
	output logic             current_mode_bit3_o,
	output logic             safe_torque_off_active_o,
	output logic             safety_channel_a_o,
	output logic             safety_channel_b_o,
	output logic             alarm_active_o,
	output logic             irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// control cycle timer

	// free-running from reset, so the tick phase is fixed by reset release
	localparam logic [`SMSS_CNT_W-1:0] CYC_LAST = `SMSS_CNT_W'(`SMSS_CTRL_CYCLES - 1);

	logic [`SMSS_CNT_W-1:0] cyc_cnt_q;
	logic [`SMSS_CNT_W-1:0] cyc_cnt_d;
	wire                    tick;

	assign tick      = (cyc_cnt_q == CYC_LAST);
	assign cyc_cnt_d = tick ? '0 : cyc_cnt_q + 1'b1;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_cnt_q <= '0;
		end else begin
			cyc_cnt_q <= cyc_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// wishbone slave decode

	logic                  ack_q;
	logic [31:0]           rdat_q;
	logic [`SMSS_CMD_W-1:0] cmd_q;
	logic [`SMSS_IRQ_W-1:0] irq_mask_q;
	logic [`SMSS_IRQ_W-1:0] irq_stat_q;
	logic [`SMSS_IRQ_W-1:0] irq_stat_d;
	wire  [`SMSS_IRQ_W-1:0] irq_ev;

	wire        req;
	wire        acc;
	wire        wr;
	wire        rd;
	wire        hit_cmd;
	wire        hit_mon;
	wire        hit_stat;
	wire        hit_istat;
	wire        hit_imask;
	wire        hit_pos;
	wire        hit_alarm;
	wire [31:0] rdat_d;

	assign req       = wb_cyc_i && wb_stb_i;
	assign acc       = req && !ack_q;
	assign wr        = acc && wb_we_i;
	assign rd        = acc && !wb_we_i;
	assign hit_cmd   = (wb_adr_i == `SMSS_OFS_CMD);
	assign hit_mon   = (wb_adr_i == `SMSS_OFS_MON);
	assign hit_stat  = (wb_adr_i == `SMSS_OFS_STAT);
	assign hit_istat = (wb_adr_i == `SMSS_OFS_IRQ_STAT);
	assign hit_imask = (wb_adr_i == `SMSS_OFS_IRQ_MASK);
	assign hit_pos   = (wb_adr_i == `SMSS_OFS_REF_POS);
	assign hit_alarm = (wb_adr_i == `SMSS_OFS_ALARM);

	// only byte lane 0 holds writable bits; the other lanes are ignored
	// controller command register: the controller side of the request, stop, alarm reset and mode inputs (not the safety channels or STO)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q      <= `SMSS_CMD_RST;
			irq_mask_q <= `SMSS_IRQ_MASK_RST;
		end else begin
			if (wr && hit_cmd && wb_sel_i[0]) begin
				cmd_q <= wb_dat_i[`SMSS_CMD_W-1:0];
			end
			if (wr && hit_imask && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[`SMSS_IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// input devices: external pin or controller command; safety channels and STO from pins only

	logic       ref_req_q;
	logic       zp_req_q;
	logic       emg_q;
	logic       alm_rst_q;
	logic [2:0] mode_sel_q;
	logic       chan_a_q;
	logic       chan_b_q;
	logic       sto_q;

	wire        ref_req_in;
	wire        zp_req_in;
	wire        emg_in;
	wire        alm_rst_in;
	wire [2:0]  mode_sel_in;

	assign ref_req_in  = ext_ref_point_set_request_i | cmd_q[`SMSS_B_REF_REQ];
	assign zp_req_in   = ext_zero_pulse_recreate_request_i | cmd_q[`SMSS_B_ZP_REQ];
	assign emg_in      = ext_controller_emergency_stop_i | cmd_q[`SMSS_B_EMG];
	assign alm_rst_in  = ext_alarm_reset_input_i | cmd_q[`SMSS_B_ALM_RST];
	assign mode_sel_in = ext_mode_select_i | cmd_q[`SMSS_B_MODE_HI:`SMSS_B_MODE_LO];

	// everything is taken on the same tick so status bits stay coherent
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ref_req_q  <= 1'b0;
			zp_req_q   <= 1'b0;
			emg_q      <= 1'b0;
			alm_rst_q  <= 1'b0;
			mode_sel_q <= 3'h0;
			chan_a_q   <= 1'b0;
			chan_b_q   <= 1'b0;
			sto_q      <= 1'b0;
		end else if (tick) begin
			ref_req_q  <= ref_req_in;
			zp_req_q   <= zp_req_in;
			emg_q      <= emg_in;
			alm_rst_q  <= alm_rst_in;
			mode_sel_q <= mode_sel_in;
			chan_a_q   <= safety_channel_a_input_i;
			chan_b_q   <= safety_channel_b_input_i;
			sto_q      <= sto_shutoff_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference point data set

	logic        done_q;
	logic        err_q;
	logic [31:0] ref_pos_q;
	wire         ref_rise;

	assign ref_rise = tick && ref_req_in && !ref_req_q;

	// a new request clears the old verdict and stores a fresh point if the position is valid
	// a failed update keeps the last good point so the axis stays referenced
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			done_q    <= 1'b0;
			err_q     <= 1'b0;
			ref_pos_q <= 32'h0000_0000;
		end else if (ref_rise) begin
			if (position_valid_i) begin
				ref_pos_q <= position_i;
			end
			done_q <= position_valid_i;
			err_q  <= !position_valid_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control mode in effect

	smss_mode_t mode_q;
	smss_mode_t mode_d;
	logic [2:0] mode_bits;

	// both low bits set without bit 3 is not a mode: keep the current one
	always_comb begin
		mode_d = mode_q;
		if (mode_sel_in[2]) begin
			mode_d = SMSS_MODE_CONT_TORQUE;
		end else begin
			case (mode_sel_in[1:0])
				2'h0:    mode_d = SMSS_MODE_POSITION;
				2'h1:    mode_d = SMSS_MODE_SPEED;
				2'h2:    mode_d = SMSS_MODE_TORQUE_LIMIT;
				default: mode_d = mode_q;
			endcase
		end
	end

	// continuous-to-torque drives the two undefined bits low
	always_comb begin
		case (mode_q)
			SMSS_MODE_POSITION:     mode_bits = 3'h0;
			SMSS_MODE_SPEED:        mode_bits = 3'h1;
			SMSS_MODE_TORQUE_LIMIT: mode_bits = 3'h2;
			SMSS_MODE_CONT_TORQUE:  mode_bits = 3'h4;
			default:                mode_bits = 3'h0;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= SMSS_MODE_POSITION;
		end else if (tick) begin
			mode_q <= mode_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// alarms

	smss_alarm_if alm_if ();

	assign alm_if.event_set   = alarm_event_i;
	// reset acts on the rising edge of the sampled input, not on its level
	assign alm_if.reset_pulse = tick && alm_rst_in && !alm_rst_q;

	smss_alarm u_alarm (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.alm   (alm_if.latch)
	);

	////////////////////////////////////////////////////////////////////////////////
	// interrupts

	// the alarm interrupt lags the latch by a clock: only new bits count
	assign irq_ev[`SMSS_I_DONE]  = ref_rise && position_valid_i;
	assign irq_ev[`SMSS_I_ERR]   = ref_rise && !position_valid_i;
	assign irq_ev[`SMSS_I_ALARM] = alm_if.raised;
	assign irq_ev[`SMSS_I_STO]   = tick && sto_shutoff_i && !sto_q;
	assign irq_ev[`SMSS_I_MODE]  = tick && (mode_d != mode_q);

	// an event in the clearing read cycle survives the clear
	assign irq_stat_d = irq_ev | ((rd && hit_istat) ? '0 : irq_stat_q);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux and acknowledge

	wire [31:0] mon_word;
	wire [31:0] stat_word;

	assign mon_word  = {23'h0, chan_b_q, chan_a_q, mode_sel_q, alm_rst_q, emg_q,
		zp_req_q, ref_req_q};
	assign stat_word = {24'h0, zp_req_q, |alm_if.active, sto_q, mode_bits, err_q, done_q};

	// unmapped offsets read as zero and are still acknowledged
	assign rdat_d = hit_cmd   ? {25'h0, cmd_q} :
		hit_mon   ? mon_word :
		hit_stat  ? stat_word :
		hit_istat ? {27'h0, irq_stat_q} :
		hit_imask ? {27'h0, irq_mask_q} :
		hit_pos   ? ref_pos_q :
		hit_alarm ? {24'h0, alm_if.active} : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			if (rd) begin
				rdat_q <= rdat_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign wb_ack_o                      = ack_q;
	assign wb_dat_o                      = rdat_q;
	assign ref_point_set_request_o       = ref_req_q;
	assign ref_point_set_complete_o      = done_q;
	assign ref_point_set_error_o         = err_q;
	assign ref_point_data_o              = ref_pos_q;
	assign zero_pulse_recreate_request_o = zp_req_q;
	assign controller_emergency_stop_o   = emg_q;
	assign alarm_reset_input_o           = alm_rst_q;
	assign current_mode_bit1_o           = mode_bits[0];
	assign current_mode_bit2_o           = mode_bits[1];
	assign current_mode_bit3_o           = mode_bits[2];
	assign safe_torque_off_active_o      = sto_q;
	assign safety_channel_a_o            = chan_a_q;
	assign safety_channel_b_o            = chan_b_q;
	assign alarm_active_o                = |alm_if.active;
	assign irq_o                         = |(irq_stat_q & irq_mask_q);

endmodule

`default_nettype wire

// ==== sim/smss_top_monitor.sv ====
// port checker for the servo status block
// assumes a control tick every 200 clocks counted from reset release
`timescale 1ns/1ps
`default_nettype none

module smss_top_monitor (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       ext_zero_pulse_recreate_request_i,
	input wire logic       ext_controller_emergency_stop_i,
	input wire logic [2:0] ext_mode_select_i,
	input wire logic       safety_channel_a_input_i,
	input wire logic       safety_channel_b_input_i,
	input wire logic       sto_shutoff_i,
	input wire logic [7:0] alarm_event_i,
	input wire logic       ref_point_set_complete_o,
	input wire logic       ref_point_set_error_o,
	input wire logic       zero_pulse_recreate_request_o,
	input wire logic       controller_emergency_stop_o,
	input wire logic       current_mode_bit1_o,
	input wire logic       current_mode_bit2_o,
	input wire logic       current_mode_bit3_o,
	input wire logic       safe_torque_off_active_o,
	input wire logic       safety_channel_a_o,
	input wire logic       safety_channel_b_o,
	input wire logic       alarm_active_o
);
	logic [7:0] cnt_q;
	logic       tick;
	logic [8:0] outs;

	// mirrors the design's tick so sampling moments can be pinned down
	assign tick = (cnt_q == 8'hC7);
	assign outs = {zero_pulse_recreate_request_o, controller_emergency_stop_o,
		current_mode_bit1_o, current_mode_bit2_o, current_mode_bit3_o,
		safe_torque_off_active_o, safety_channel_a_o, safety_channel_b_o,
		ref_point_set_complete_o};

	always_ff @(posedge clk_i) begin
		cnt_q <= (rst_i || tick) ? 8'h00 : cnt_q + 8'h01;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	////////////////////////////////////////////////////////////////////////////////
	a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_outs_at_tick: assert property (!tick |=> $stable(outs))
		else $error("output changed between ticks");
	a_zp_pin_on: assert property (tick && ext_zero_pulse_recreate_request_i
		|=> zero_pulse_recreate_request_o)
		else $error("zero pulse request not shown");
	a_emg_pin_on: assert property (tick && ext_controller_emergency_stop_i
		|=> controller_emergency_stop_o)
		else $error("emergency stop not shown");
	a_mode_bit3_wins: assert property (tick && ext_mode_select_i[2]
		|=> current_mode_bit3_o && !current_mode_bit1_o && !current_mode_bit2_o)
		else $error("continuous torque mode not shown");
	a_mode_one_hot: assert property (
		$onehot0({current_mode_bit1_o, current_mode_bit2_o, current_mode_bit3_o}))
		else $error("two mode bits at once");
	a_sto_follows: assert property (tick
		|=> safe_torque_off_active_o == $past(sto_shutoff_i)
		&& safety_channel_a_o == $past(safety_channel_a_input_i)
		&& safety_channel_b_o == $past(safety_channel_b_input_i))
		else $error("safety state not reported");
	a_done_err_apart: assert property (
		!(ref_point_set_complete_o && ref_point_set_error_o))
		else $error("complete and error together");
	a_alarm_kept: assert property (alarm_event_i[7] |=> alarm_active_o [*8])
		else $error("protected alarm dropped");
endmodule

bind smss_top smss_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.ext_zero_pulse_recreate_request_i(ext_zero_pulse_recreate_request_i),
	.ext_controller_emergency_stop_i(ext_controller_emergency_stop_i),
	.ext_mode_select_i(ext_mode_select_i), .safety_channel_a_input_i(safety_channel_a_input_i),
	.safety_channel_b_input_i(safety_channel_b_input_i), .sto_shutoff_i(sto_shutoff_i),
	.alarm_event_i(alarm_event_i), .ref_point_set_complete_o(ref_point_set_complete_o),
	.ref_point_set_error_o(ref_point_set_error_o),
	.zero_pulse_recreate_request_o(zero_pulse_recreate_request_o),
	.controller_emergency_stop_o(controller_emergency_stop_o),
	.current_mode_bit1_o(current_mode_bit1_o), .current_mode_bit2_o(current_mode_bit2_o),
	.current_mode_bit3_o(current_mode_bit3_o), .safe_torque_off_active_o(safe_torque_off_active_o),
	.safety_channel_a_o(safety_channel_a_o), .safety_channel_b_o(safety_channel_b_o),
	.alarm_active_o(alarm_active_o));

`default_nettype wire

// ==== sim/smss_ctrl_model.sv ====
// motion controller model: issues commands as a classic wishbone master
// assumes the slave acks every request; a missing ack is reported via ok
`timescale 1ns/1ps
`default_nettype none

module smss_ctrl_model (
	input  wire logic        clk_i,
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [31:0]      wb_dat_o,
	output logic [3:0]       wb_sel_o,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_i
);
	initial begin
		{wb_cyc_o, wb_stb_o, wb_we_o} = 3'h0;
		wb_adr_o = 8'h00;
		wb_dat_o = 32'h0;
		wb_sel_o = 4'hF;
	end

	// mode and stop commands reach the device through this access or through the external pins the bench drives
	task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] wd,
		output logic [31:0] rd, output bit ok);
		int n;
		@(posedge clk_i);
		{wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
		wb_adr_o <= adr;
		wb_dat_o <= wd;
		ok = 1'b0;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clk_i);
			ok = (wb_ack_i === 1'b1);
		end
		rd = wb_dat_i;
		{wb_cyc_o, wb_stb_o, wb_we_o} <= 3'h0;
		wb_dat_o <= ~wd;
	endtask
endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
// self-checking bench for the servo status block
// assumes the monitor is bound and the tick period is 200 clocks
`timescale 1ns/1ps
`default_nettype none
`include "smss_regs.svh"

module tb_top;
	import smss_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc, stb, we, ack;
	logic [7:0]  adr, alarm_event_i = 8'h00;
	logic [31:0] wdat, rdat, position_i = 32'h0, d, pos;
	logic [3:0]  sel;
	logic [2:0]  ext_mode = 3'h0, m;
	logic [3:0]  mon_exp;
	logic        e_ref = 1'b0, e_zp = 1'b0, e_emg = 1'b0, e_rst = 1'b0;
	logic        ch_a = 1'b0, ch_b = 1'b0, safe_torque_off_active = 1'b0, pvalid = 1'b0;
	logic        ref_req, done, err, zp, controller_emergency_stop, arst, mb1, mb2, mb3, sto_o, cha, chb, alm, irq;
	logic [31:0] ref_data;
	int          num_errors = 0, n_compared = 0, i, exp_mode = 0;
	int          mode_seq[$] = '{0, 1, 2, 7, 3};
	bit          ok;

	always #2.5 clk_i = ~clk_i;

	smss_ctrl_model ctl (.clk_i(clk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_dat_o(wdat), .wb_sel_o(sel), .wb_dat_i(rdat), .wb_ack_i(ack));

	smss_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.ext_ref_point_set_request_i(e_ref), .ext_zero_pulse_recreate_request_i(e_zp),
		.ext_controller_emergency_stop_i(e_emg), .ext_alarm_reset_input_i(e_rst),
		.ext_mode_select_i(ext_mode), .safety_channel_a_input_i(ch_a),
		.safety_channel_b_input_i(ch_b), .sto_shutoff_i(safe_torque_off_active), .position_i(position_i),
		.position_valid_i(pvalid), .alarm_event_i(alarm_event_i),
		.ref_point_set_request_o(ref_req), .ref_point_set_complete_o(done),
		.ref_point_set_error_o(err), .ref_point_data_o(ref_data),
		.zero_pulse_recreate_request_o(zp), .controller_emergency_stop_o(controller_emergency_stop),
		.alarm_reset_input_o(arst), .current_mode_bit1_o(mb1), .current_mode_bit2_o(mb2),
		.current_mode_bit3_o(mb3), .safe_torque_off_active_o(sto_o), .safety_channel_a_o(cha),
		.safety_channel_b_o(chb), .alarm_active_o(alm), .irq_o(irq));

	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		ctl.access(w, a, v, d, ok);
		if (!ok) begin
			num_errors++;
			$display("[FAIL] %0t no ack", $time);
			conclude();
		end
	endtask

	// one full period guarantees a tick landed, whatever the phase
	task automatic wait_tick();
		repeat (201) @(posedge clk_i);
	endtask

	// mode model: bit3 wins; both low bits without bit3 is no mode and keeps the last
	function automatic int mode_model(input int sel, input int prev);
		if ((sel & 4) != 0) return 4;
		if (sel == 3) return prev;
		return sel;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6323));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(0, `SMSS_OFS_IRQ_MASK, 0);
		chk(d, 32'h0, "mask reset");
		bus(0, 8'h40, 0);
		chk(d, 32'h0, "unmapped read");
		chk({mb3, mb2, mb1, done, err, irq}, 6'h00, "reset outputs");
		foreach (mode_seq[k]) begin
			m = 3'(mode_seq[k]);
			exp_mode = mode_model(mode_seq[k], exp_mode);
			bus(1, `SMSS_OFS_CMD, 32'(m) << `SMSS_B_MODE_LO);
			wait_tick();
			chk({mb3, mb2, mb1}, 32'(exp_mode), "mode pins");
			bus(0, `SMSS_OFS_STAT, 0);
			chk(d[4:2], 32'(exp_mode), "mode status");
		end
		for (i = 0; i < 6; i++) begin
			pos = $urandom;
			m = 3'($urandom);
			mon_exp = {pos[0], pos[1], {pos[3], pos[4]} | m[1:0]};
			{e_zp, e_emg, safe_torque_off_active, ch_a, ch_b} <= pos[4:0];
			bus(1, `SMSS_OFS_CMD, {29'h0, m[1:0], 1'b0});
			wait_tick();
			chk({controller_emergency_stop, zp}, mon_exp[1:0], "combined");
			chk({sto_o, cha, chb}, pos[2:0], "safety state");
			bus(0, `SMSS_OFS_MON, 0);
			chk({d[8:7], d[2:1]}, mon_exp, "monitor");
		end
		{e_zp, e_emg, safe_torque_off_active, ch_a, ch_b} <= 5'h00;
		bus(1, `SMSS_OFS_CMD, 0);
		bus(1, `SMSS_OFS_IRQ_MASK, 32'h1 << `SMSS_I_DONE);
		bus(0, `SMSS_OFS_IRQ_STAT, 0);
		pos = $urandom;
		position_i <= pos;
		pvalid <= 1'b1;
		bus(1, `SMSS_OFS_CMD, 32'h1);
		wait_tick();
		chk(ref_req, 1'b1, "ref request");
		chk(ref_data, pos, "ref data stored");
		chk({err, done}, 2'b01, "ref complete");
		chk(irq, 1'b1, "irq raised");
		bus(0, `SMSS_OFS_IRQ_STAT, 0);
		chk(d[0], 1'b1, "irq status");
		chk(irq, 1'b0, "irq cleared by read");
		bus(0, `SMSS_OFS_REF_POS, 0);
		chk(d, pos, "ref register");
		bus(1, `SMSS_OFS_CMD, 0);
		wait_tick();
		pvalid <= 1'b0;
		position_i <= ~pos;
		e_ref <= 1'b1;
		wait_tick();
		chk({err, done}, 2'b10, "ref error");
		chk(ref_data, pos, "ref data kept");
		e_ref <= 1'b0;
		alarm_event_i <= 8'h81;
		@(posedge clk_i);
		alarm_event_i <= 8'h00;
		bus(0, `SMSS_OFS_ALARM, 0);
		chk(d, 32'h81, "alarm latched");
		e_rst <= 1'b1;
		wait_tick();
		chk(arst, 1'b1, "alarm reset shown");
		e_rst <= 1'b0;
		repeat (2) @(posedge clk_i);
		bus(0, `SMSS_OFS_ALARM, 0);
		chk(d, 32'h80, "alarm reset");
		chk(alm, 1'b1, "protected alarm active");
		conclude();
	end
endmodule

`default_nettype wire
